// >>> hw/stpfc_indexer.sv
// stepper indexer with fault shutdown, lockout, standby and AHB-Lite control registers
//
// Notes on behaviour
// - latch mode holds a thermal or over-current shutdown until reset or enable toggle.
// - auto mode leaves a thermal or over-current shutdown on its own.
// - in standby thermal always auto-returns and over-current detection is off.
// - with either supply below protection threshold, no thermal or over-current protection.
// - thermal auto return resumes at a charge start, second chop start after clear.
// - a shutdown acts like enable low; counter keeps running meanwhile.
// - any single switch over-current turns all switches off and holds them off.
// - over-current shorter than about four microseconds is ignored.
// - in auto mode outputs come back after the over-current off period.
// - undervoltage on either supply turns outputs off, forces initial state, auto resumes.
// - fault flag pulled low while thermal or over-current shutdown is active.
// - home flag pulled low while indexer sits at the initial state.
// - mode bits decode 001 full, 010 half A, 011 half B, 100/101/110 finer.
// - any change of step mode restarts from the initial state.
// - set points come from a seventeen-entry sine table, zero to full scale.
// - each rising step clock edge moves one position of the selected mode.
// - outputs off while enable low, driven while enable high.
// - enable low, run low: outputs off, current setting held at initial state.
// - enable low, run high: outputs off, counter still follows step edges.
// - enable high, run low: initial currents driven, phase A full scale.
// - enable high, run high: currents follow the step counter.
// - all mode bits equal means standby: only protection runs, home flag released.
// - for about 200 us after standby release control inputs are ignored.
// - initial state is A full; B negative full in full step, else zero.
// - direction low is clockwise, high counter-clockwise.
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "stpfc_params.svh"
module stpfc_indexer #(
	parameter int BLANK_CYCLES = `STPFC_BLANK_CYC,
	parameter int OC_OFF_CYCLES = `STPFC_OC_OFF_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic step_clk,
	input wire logic thermal_hot,
	input wire logic [7:0] oc_switch,
	input wire logic chop_charge_start,
	input wire logic prot_supply_ok_a,
	input wire logic prot_supply_ok_b,
	input wire logic undervoltage_lockout_a,
	input wire logic undervoltage_lockout_b,
	output logic bridge_en,
	output logic [9:0] phase_a_level,
	output logic phase_a_neg,
	output logic [9:0] phase_b_level,
	output logic phase_b_neg,
	output logic fault_flag_o,
	output logic fault_flag_oe,
	output logic home_position_flag_o,
	output logic home_position_flag_oe
);
	import stpfc_pkg::*;

	typedef struct packed {
		logic ctrl_en;
		logic ctrl_run;
		logic ctrl_dir;
		logic ctrl_auto;
		logic [2:0] ctrl_mode;
		logic en_q;
		logic step_q;
		stpfc_mode_t mode_q;
		logic [15:0] blank_cnt;
		stpfc_th_t th;
		stpfc_oc_t oc;
		logic [15:0] oc_cnt;
		logic [5:0] pos;
		logic a_neg_p;
		logic b_neg_p;
		logic [9:0] a_level;
		logic a_neg;
		logic [9:0] b_level;
		logic b_neg;
		logic bridge_en;
		logic fault_oe;
		logic home_oe;
		logic [31:0] hrdata;
		logic hready;
		logic pend;
		logic pwrite;
		logic [7:0] paddr;
	} stpfc_state_t;

	stpfc_state_t st;
	stpfc_state_t next_st;

	logic oc_trip;
	logic [4:0] rom_addr_a;
	logic [4:0] rom_addr_b;
	logic [9:0] rom_data_a;
	logic [9:0] rom_data_b;

	function automatic stpfc_mode_t decode_mode(input logic [2:0] sel);
		case (sel)
			3'b001: decode_mode = MODE_FULL;
			3'b010: decode_mode = MODE_HALF_A;
			3'b011: decode_mode = MODE_HALF_B;
			3'b100: decode_mode = MODE_QUARTER;
			3'b101: decode_mode = MODE_EIGHTH;
			3'b110: decode_mode = MODE_SIXTEENTH;
			default: decode_mode = MODE_STANDBY;
		endcase
	endfunction

	function automatic logic [5:0] stride_of(input stpfc_mode_t m);
		case (m)
			MODE_FULL: stride_of = 6'h10;
			MODE_HALF_A: stride_of = 6'h08;
			MODE_HALF_B: stride_of = 6'h08;
			MODE_QUARTER: stride_of = 6'h04;
			MODE_EIGHTH: stride_of = 6'h02;
			default: stride_of = 6'h01;
		endcase
	endfunction

	function automatic logic [5:0] init_pos(input stpfc_mode_t m);
		// full step starts at -45 degrees so both phases sit at full scale
		init_pos = (m == MODE_FULL) ? `STPFC_FULL_INIT_POS : `STPFC_INIT_POS;
	endfunction

	// cosine of a 64-step electrical turn: {negative, table index}
	function automatic logic [5:0] phase_of(input logic [5:0] p);
		logic [3:0] k;
		logic [4:0] idx;
		logic neg;
		k = p[3:0];
		idx = 5'h00;
		neg = 1'b0;
		case (p[5:4])
			2'h0: begin
				idx = `STPFC_IDX_FULL - {1'b0, k};
			end
			2'h1: begin
				idx = {1'b0, k};
				neg = (k != 4'h0);
			end
			2'h2: begin
				idx = `STPFC_IDX_FULL - {1'b0, k};
				neg = 1'b1;
			end
			default: begin
				idx = {1'b0, k};
			end
		endcase
		phase_of = {neg, idx};
	endfunction

	// two-level modes clamp every non-zero set point to full scale
	function automatic logic [4:0] rom_index(input stpfc_mode_t m, input logic [4:0] idx);
		if ((m == MODE_FULL || m == MODE_HALF_B) && idx != 5'h00) begin
			rom_index = `STPFC_IDX_FULL;
		end else begin
			rom_index = idx;
		end
	endfunction

	stpfc_mode_t mode;
	logic standby;
	logic hold;
	logic undervoltage_lockout;
	logic prot_on;
	logic auto_ret;
	logic en_rise;
	logic step_rise;
	logic oc_any;
	logic oc_arm;
	logic [5:0] pa;
	logic [5:0] pb;
	logic [5:0] init;

	always_comb begin
		mode = decode_mode(st.ctrl_mode);
		standby = (mode == MODE_STANDBY);
		// release cycle and blanking window ignore control inputs
		hold = standby || st.mode_q == MODE_STANDBY || st.blank_cnt != 16'h0000;
		undervoltage_lockout = undervoltage_lockout_a | undervoltage_lockout_b;
		prot_on = prot_supply_ok_a & prot_supply_ok_b;
		auto_ret = st.ctrl_auto | standby;
		en_rise = st.ctrl_en & ~st.en_q;
		step_rise = step_clk & ~st.step_q;
		oc_any = |oc_switch;
		oc_arm = prot_on & ~undervoltage_lockout & ~standby;
		init = init_pos(mode);
		pa = phase_of(st.pos);
		pb = phase_of(st.pos - `STPFC_QUARTER_TURN);
		rom_addr_a = rom_index(st.mode_q, pa[4:0]);
		rom_addr_b = rom_index(st.mode_q, pb[4:0]);
	end

	always_comb begin
		next_st = st;
		next_st.en_q = st.ctrl_en;
		next_st.step_q = step_clk;
		next_st.mode_q = mode;

		// bus slave: one wait state, data phase resolved on the pending cycle
		if (st.pend) begin
			next_st.pend = 1'b0;
			next_st.hready = 1'b1;
			if (st.pwrite) begin
				if (st.paddr == `STPFC_REG_CTRL) begin
					next_st.ctrl_en = hwdata[`STPFC_CTRL_ENABLE];
					next_st.ctrl_run = hwdata[`STPFC_CTRL_RUN];
					next_st.ctrl_dir = hwdata[`STPFC_CTRL_DIR];
					next_st.ctrl_auto = hwdata[`STPFC_CTRL_AUTO];
					next_st.ctrl_mode = hwdata[`STPFC_CTRL_MODE_HI:`STPFC_CTRL_MODE_LO];
				end
			end else begin
				case (st.paddr)
					`STPFC_REG_CTRL: next_st.hrdata = {25'h0, st.ctrl_mode, st.ctrl_auto,
						st.ctrl_dir, st.ctrl_run, st.ctrl_en};
					`STPFC_REG_STATUS: next_st.hrdata = {18'h0, st.pos, 1'b0, st.home_oe,
						st.bridge_en, hold, standby, undervoltage_lockout, st.oc != OC_OK, st.th != TH_OK};
					`STPFC_REG_PHASE: next_st.hrdata = {5'h0, st.b_neg, st.b_level, 5'h0,
						st.a_neg, st.a_level};
					default: next_st.hrdata = 32'h0000_0000;
				endcase
			end
		end else if (hsel && htrans[1] && hready) begin
			next_st.pend = 1'b1;
			next_st.hready = 1'b0;
			next_st.pwrite = hwrite;
			next_st.paddr = haddr[7:0];
		end

		if (standby) begin
			next_st.blank_cnt = 16'h0000;
		end else if (st.mode_q == MODE_STANDBY) begin
			next_st.blank_cnt = 16'(BLANK_CYCLES);
		end else if (st.blank_cnt != 16'h0000) begin
			next_st.blank_cnt = st.blank_cnt - 16'h0001;
		end

		// lockout also plays the part of a power cycle for latched faults
		if (!prot_on || undervoltage_lockout) begin
			next_st.th = TH_OK;
		end else begin
			case (st.th)
				TH_OK: begin
					if (thermal_hot) next_st.th = TH_SHUT;
				end
				TH_SHUT: begin
					if (!thermal_hot && auto_ret) begin
						next_st.th = TH_ARM;
					end else if (!thermal_hot && en_rise) begin
						next_st.th = TH_OK;
					end
				end
				TH_ARM: begin
					if (thermal_hot) begin
						next_st.th = TH_SHUT;
					end else if (chop_charge_start) begin
						next_st.th = TH_ALIGN;
					end
				end
				TH_ALIGN: begin
					if (thermal_hot) begin
						next_st.th = TH_SHUT;
					end else if (chop_charge_start) begin
						next_st.th = TH_OK;
					end
				end
				default: next_st.th = TH_OK;
			endcase
		end

		if (!oc_arm) begin
			next_st.oc = OC_OK;
			next_st.oc_cnt = 16'h0000;
		end else begin
			case (st.oc)
				OC_OK: begin
					next_st.oc_cnt = 16'h0000;
					if (oc_trip) next_st.oc = auto_ret ? OC_OFF : OC_SHUT;
				end
				OC_SHUT: begin
					if (auto_ret) begin
						next_st.oc = OC_OFF;
					end else if (en_rise && !oc_any) begin
						next_st.oc = OC_OK;
					end
				end
				OC_OFF: begin
					next_st.oc_cnt = st.oc_cnt + 16'h0001;
					if (st.oc_cnt == 16'(OC_OFF_CYCLES - 1)) begin
						next_st.oc = OC_OK;
					end
				end
				default: next_st.oc = OC_OK;
			endcase
		end

		// the counter keeps running through enable low and shutdowns
		if (undervoltage_lockout || hold || !st.ctrl_run || mode != st.mode_q) begin
			next_st.pos = init;
		end else if (step_rise) begin
			if (st.ctrl_dir) begin
				next_st.pos = st.pos - stride_of(mode);
			end else begin
				next_st.pos = st.pos + stride_of(mode);
			end
		end

		next_st.a_neg_p = pa[5];
		next_st.b_neg_p = pb[5];
		next_st.a_level = rom_data_a;
		next_st.a_neg = st.a_neg_p;
		next_st.b_level = rom_data_b;
		next_st.b_neg = st.b_neg_p;

		next_st.bridge_en = st.ctrl_en && !hold && !undervoltage_lockout && next_st.th == TH_OK
			&& next_st.oc == OC_OK;
		next_st.fault_oe = (next_st.th != TH_OK) || (next_st.oc != OC_OK);
		next_st.home_oe = !standby && next_st.pos == init;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
			st.hready <= 1'b1;
		end else if (ce) begin
			st <= next_st;
		end
	end

	stpfc_oc_filter u_oc_filter (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.arm(oc_arm),
		.raw(oc_any),
		.trip(oc_trip)
	);

	stpfc_sine_rom u_sine_rom (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.addr_a(rom_addr_a),
		.addr_b(rom_addr_b),
		.data_a(rom_data_a),
		.data_b(rom_data_b)
	);

	assign hrdata = st.hrdata;
	assign hreadyout = st.hready;
	assign hresp = 1'b0;
	assign bridge_en = st.bridge_en;
	assign phase_a_level = st.a_level;
	assign phase_a_neg = st.a_neg;
	assign phase_b_level = st.b_level;
	assign phase_b_neg = st.b_neg;
	// open-drain pins only ever pull low
	assign fault_flag_o = 1'b0;
	assign fault_flag_oe = st.fault_oe;
	assign home_position_flag_o = 1'b0;
	assign home_position_flag_oe = st.home_oe;
endmodule

// >>> hw/stpfc_oc_filter.sv
// noise mask on the combined over-current indication
`timescale 1ns/1ps
`include "stpfc_params.svh"
module stpfc_oc_filter (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic arm,
	input wire logic raw,
	output logic trip
);
	import stpfc_pkg::*;

	localparam logic [7:0] MASK_CYC = 8'(`STPFC_OC_MASK_CYC);

	stpfc_filt_state_t st;
	stpfc_filt_state_t next_st;

	always_comb begin
		next_st = st;
		if (!arm || !raw) begin
			next_st.cnt = 8'h00;
			next_st.trip = 1'b0;
		end else begin
			// a glitch shorter than the mask restarts the count from zero
			if (st.cnt != MASK_CYC) begin
				next_st.cnt = st.cnt + 8'h01;
			end
			next_st.trip = (st.cnt == MASK_CYC);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign trip = st.trip;
endmodule

// >>> hw/stpfc_params.svh
// offsets, field positions, reset values and timing counts of the stepper indexer
`ifndef STPFC_PARAMS_SVH
`define STPFC_PARAMS_SVH

`define STPFC_REG_CTRL 8'h00
`define STPFC_REG_STATUS 8'h04
`define STPFC_REG_PHASE 8'h08

`define STPFC_CTRL_ENABLE 0
`define STPFC_CTRL_RUN 1
`define STPFC_CTRL_DIR 2
`define STPFC_CTRL_AUTO 3
`define STPFC_CTRL_MODE_LO 4
`define STPFC_CTRL_MODE_HI 6
`define STPFC_CTRL_RESET 32'h0000_0000

`define STPFC_INIT_POS 6'h00
`define STPFC_FULL_INIT_POS 6'h38
`define STPFC_QUARTER_TURN 6'h10
`define STPFC_IDX_FULL 5'h10

`define STPFC_CLK_PERIOD_NS 25
`define STPFC_OC_MASK_NS 4000
`define STPFC_OC_MASK_CYC ((`STPFC_OC_MASK_NS + `STPFC_CLK_PERIOD_NS - 1) / `STPFC_CLK_PERIOD_NS)
`define STPFC_BLANK_NS 200000
`define STPFC_BLANK_CYC ((`STPFC_BLANK_NS + `STPFC_CLK_PERIOD_NS - 1) / `STPFC_CLK_PERIOD_NS)
`define STPFC_OC_OFF_NS 500000
`define STPFC_OC_OFF_CYC ((`STPFC_OC_OFF_NS + `STPFC_CLK_PERIOD_NS - 1) / `STPFC_CLK_PERIOD_NS)

`endif

// >>> hw/stpfc_pkg.sv
// types shared by the stepper indexer modules
package stpfc_pkg;
	typedef enum logic [2:0] {
		MODE_STANDBY,
		MODE_FULL,
		MODE_HALF_A,
		MODE_HALF_B,
		MODE_QUARTER,
		MODE_EIGHTH,
		MODE_SIXTEENTH
	} stpfc_mode_t;

	typedef enum logic [1:0] {
		TH_OK,
		TH_SHUT,
		TH_ARM,
		TH_ALIGN
	} stpfc_th_t;

	typedef enum logic [1:0] {
		OC_OK,
		OC_SHUT,
		OC_OFF
	} stpfc_oc_t;

	typedef struct packed {
		logic [7:0] cnt;
		logic trip;
	} stpfc_filt_state_t;

	typedef struct packed {
		logic [9:0] data_a;
		logic [9:0] data_b;
	} stpfc_rom_state_t;
endpackage

// >>> hw/stpfc_sine_rom.sv
// two-port sine level table in tenths of a percent, registered read data
`timescale 1ns/1ps
`include "stpfc_params.svh"
module stpfc_sine_rom (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic [4:0] addr_a,
	input wire logic [4:0] addr_b,
	output logic [9:0] data_a,
	output logic [9:0] data_b
);
	import stpfc_pkg::*;

	stpfc_rom_state_t st;
	stpfc_rom_state_t next_st;

	function automatic logic [9:0] sine_level(input logic [4:0] idx);
		case (idx)
			5'h00: sine_level = 10'h000;
			5'h01: sine_level = 10'h062;
			5'h02: sine_level = 10'h0C3;
			5'h03: sine_level = 10'h122;
			5'h04: sine_level = 10'h17F;
			5'h05: sine_level = 10'h1D7;
			5'h06: sine_level = 10'h22C;
			5'h07: sine_level = 10'h27A;
			5'h08: sine_level = 10'h2C3;
			5'h09: sine_level = 10'h305;
			5'h0A: sine_level = 10'h33F;
			5'h0B: sine_level = 10'h372;
			5'h0C: sine_level = 10'h39C;
			5'h0D: sine_level = 10'h3BD;
			5'h0E: sine_level = 10'h3D5;
			5'h0F: sine_level = 10'h3E3;
			default: sine_level = 10'h3E8;
		endcase
	endfunction

	always_comb begin
		next_st = st;
		next_st.data_a = sine_level(addr_a);
		next_st.data_b = sine_level(addr_b);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign data_a = st.data_a;
	assign data_b = st.data_b;
endmodule

// >>> verification/stpfc_indexer_checker.sv
// assertions on the stepper indexer ports
`timescale 1ns/1ps
module stpfc_indexer_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic thermal_hot,
	input wire logic [7:0] oc_switch,
	input wire logic prot_supply_ok_a,
	input wire logic prot_supply_ok_b,
	input wire logic undervoltage_lockout_a,
	input wire logic undervoltage_lockout_b,
	input wire logic bridge_en,
	input wire logic [9:0] phase_a_level,
	input wire logic phase_a_neg,
	input wire logic fault_flag_o,
	input wire logic fault_flag_oe,
	input wire logic home_position_flag_o,
	input wire logic home_position_flag_oe
);
	logic [7:0] oc_run;
	logic ok;
	assign ok = prot_supply_ok_a && prot_supply_ok_b && !undervoltage_lockout_a && !undervoltage_lockout_b && ce;
	// saturating run length of over-current samples, so a long fault cannot wrap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			oc_run <= 8'h00;
		else if (oc_switch == 8'h00)
			oc_run <= 8'h00;
		else if (oc_run != 8'hFF)
			oc_run <= oc_run + 8'h01;
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_ws;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence s_hot;
		(thermal_hot && ok)[*2];
	endsequence
	property p_ws;
		hsel && htrans[1] && hready && hreadyout && ce |=> s_ws;
	endproperty
	property p_th;
		s_hot |=> fault_flag_oe && !bridge_en;
	endproperty
	property p_trip;
		$rose(fault_flag_oe) |-> $past(thermal_hot) || $past(thermal_hot, 2) || oc_run >= 8'hA0;
	endproperty
	property p_fbr;
		fault_flag_oe |-> !bridge_en;
	endproperty
	property p_uv;
		(undervoltage_lockout_a || undervoltage_lockout_b)[*2] |-> !bridge_en;
	endproperty
	property p_np;
		(!(prot_supply_ok_a && prot_supply_ok_b))[*2] |-> !fault_flag_oe;
	endproperty
	property p_home;
		home_position_flag_oe[*4] |-> phase_a_level == 10'h3E8 && !phase_a_neg;
	endproperty
	property p_od;
		fault_flag_oe || home_position_flag_oe |-> !fault_flag_o && !home_position_flag_o;
	endproperty
	a_ws: assert property (p_ws) else $error("bus wait state not one cycle");
	a_th: assert property (p_th) else $error("no shutdown on heat");
	a_trip: assert property (p_trip) else $error("fault flag without cause");
	a_fbr: assert property (p_fbr) else $error("bridge on during fault");
	a_uv: assert property (p_uv) else $error("bridge on in lockout");
	a_np: assert property (p_np) else $error("fault with low supply");
	a_home: assert property (p_home) else $error("initial level wrong");
	a_od: assert property (p_od) else $error("open drain drives high");
endmodule
bind stpfc_indexer stpfc_indexer_checker u_chk (
	.hclk, .hresetn, .ce, .hsel, .htrans, .hready, .hreadyout, .thermal_hot,
	.oc_switch, .prot_supply_ok_a, .prot_supply_ok_b, .undervoltage_lockout_a, .undervoltage_lockout_b, .bridge_en,
	.phase_a_level, .phase_a_neg, .fault_flag_o, .fault_flag_oe, .home_position_flag_o,
	.home_position_flag_oe
);

// >>> verification/stpfc_step_host.sv
// host side step source: one request gives one step pulse
`timescale 1ns/1ps
module stpfc_step_host (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic go,
	output logic step_clk
);
	logic [2:0] cnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cnt <= 3'h0;
		else if (go)
			cnt <= 3'h4;
		else if (cnt != 3'h0)
			cnt <= cnt - 3'h1;
	end
	// two high then two low cycles, so the indexer samples each level
	assign step_clk = cnt > 3'h2;
endmodule

// >>> verification/testbench.sv
// self-checking bench for the stepper indexer
`timescale 1ns/1ps
module testbench;
	localparam int OFF = 10;
	logic hclk, hresetn, hsel, hwrite, go, step_clk, thermal_hot, chop_charge_start;
	logic prot_supply_ok_a, prot_supply_ok_b, undervoltage_lockout_a, undervoltage_lockout_b, hreadyout, bridge_en;
	logic fault_flag_oe, home_position_flag_oe, hresp, phase_b_neg;
	logic [1:0] htrans;
	logic [7:0] oc_switch;
	logic [31:0] haddr, hwdata, hrdata, d;
	int n_mismatch, n_tests;
	stpfc_indexer #(.BLANK_CYCLES(20), .OC_OFF_CYCLES(OFF)) DUT (
		.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .step_clk,
		.thermal_hot, .oc_switch, .chop_charge_start, .prot_supply_ok_a, .prot_supply_ok_b,
		.undervoltage_lockout_a, .undervoltage_lockout_b, .bridge_en, .phase_a_level(), .phase_a_neg(), .phase_b_level(),
		.phase_b_neg, .fault_flag_o(), .fault_flag_oe, .home_position_flag_o(),
		.home_position_flag_oe
	);
	stpfc_step_host host (.hclk, .hresetn, .go, .step_clk);
	always #12.5 hclk = !hclk;
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	// single slave: hready is the slave's own hreadyout
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask
	task automatic stp();
		@(posedge hclk);
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		cyc(8);
	endtask
	task automatic chop();
		@(posedge hclk);
		chop_charge_start <= 1'b1;
		@(posedge hclk);
		chop_charge_start <= 1'b0;
		cyc(3);
	endtask
	task automatic t_regs();
		bus(1'b0, 8'h00, 32'h0);
		chk("ctrl reset", 32'h0, d);
		chk("hresp", 32'h0, {31'h0, hresp});
		bus(1'b1, 8'h0C, 32'hFFFFFFFF);
		bus(1'b0, 8'h0C, 32'h0);
		chk("unmapped", 32'h0, d);
		bus(1'b1, 8'h04, 32'hFFFFFFFF);
		bus(1'b0, 8'h00, 32'h0);
		chk("ctrl", 32'h0, d);
		$display("register test done");
	endtask
	task automatic t_init();
		bus(1'b1, 8'h00, 32'h41);
		cyc(30);
		bus(1'b0, 8'h08, 32'h0);
		chk("phase quarter", 32'h03E8, d);
		chk("bridge", 32'h1, bridge_en);
		chk("home", 32'h1, home_position_flag_oe);
		bus(1'b1, 8'h00, 32'h11);
		cyc(6);
		bus(1'b0, 8'h08, 32'h0);
		chk("phase full", 32'h07E803E8, d);
		chk("phase b sign", 32'h1, {31'h0, phase_b_neg});
		$display("initial state test done");
	endtask
	task automatic t_step();
		bus(1'b1, 8'h00, 32'h61);
		cyc(6);
		bus(1'b1, 8'h00, 32'h63);
		stp();
		bus(1'b0, 8'h08, 32'h0);
		chk("phase cw", 32'h006203E3, d);
		chk("home", 32'h0, home_position_flag_oe);
		bus(1'b1, 8'h00, 32'h67);
		stp();
		stp();
		bus(1'b0, 8'h08, 32'h0);
		chk("phase ccw", 32'h046203E3, d);
		$display("step test done");
	endtask
	task automatic t_modes();
		logic [5:0] ex [6] = '{6'h08, 6'h08, 6'h08, 6'h04, 6'h02, 6'h01};
		for (int m = 1; m <= 6; m++) begin
			bus(1'b1, 8'h00, {25'h0, m[2:0], 4'h3});
			cyc(4);
			stp();
			bus(1'b0, 8'h04, 32'h0);
			chk("position", {26'h0, ex[m-1]}, {26'h0, d[13:8]});
		end
		$display("mode test done");
	endtask
	task automatic t_enlow();
		bus(1'b1, 8'h00, 32'h62);
		stp();
		chk("bridge", 32'h0, bridge_en);
		bus(1'b0, 8'h04, 32'h0);
		chk("position", 32'h2, {26'h0, d[13:8]});
		bus(1'b1, 8'h00, 32'h60);
		cyc(6);
		bus(1'b0, 8'h08, 32'h0);
		chk("phase", 32'h03E8, d);
		bus(1'b1, 8'h00, 32'h61);
		cyc(4);
		chk("bridge", 32'h1, bridge_en);
		$display("enable test done");
	endtask
	task automatic t_therm();
		thermal_hot <= 1'b1;
		cyc(3);
		chk("fault", 32'h1, fault_flag_oe);
		chk("bridge", 32'h0, bridge_en);
		thermal_hot <= 1'b0;
		cyc(6);
		chk("fault latched", 32'h1, fault_flag_oe);
		bus(1'b1, 8'h00, 32'h60);
		bus(1'b1, 8'h00, 32'h61);
		cyc(3);
		chk("fault", 32'h0, fault_flag_oe);
		bus(1'b1, 8'h00, 32'h69);
		thermal_hot <= 1'b1;
		cyc(3);
		thermal_hot <= 1'b0;
		chop();
		chk("fault", 32'h1, fault_flag_oe);
		chop();
		chk("fault", 32'h0, fault_flag_oe);
		chk("bridge", 32'h1, bridge_en);
		$display("thermal test done");
	endtask
	task automatic t_oc();
		oc_switch <= 8'h08;
		cyc(100);
		oc_switch <= 8'h00;
		cyc(3);
		chk("fault", 32'h0, fault_flag_oe);
		oc_switch <= 8'h80;
		cyc(165);
		chk("fault", 32'h1, fault_flag_oe);
		chk("bridge", 32'h0, bridge_en);
		oc_switch <= 8'h00;
		cyc(OFF + 10);
		chk("bridge", 32'h1, bridge_en);
		bus(1'b1, 8'h00, 32'h61);
		oc_switch <= 8'h01;
		cyc(165);
		oc_switch <= 8'h00;
		cyc(OFF + 10);
		chk("fault latched", 32'h1, fault_flag_oe);
		bus(1'b1, 8'h00, 32'h60);
		bus(1'b1, 8'h00, 32'h61);
		cyc(3);
		chk("fault", 32'h0, fault_flag_oe);
		$display("overcurrent test done");
	endtask
	task automatic t_supply();
		prot_supply_ok_b <= 1'b0;
		thermal_hot <= 1'b1;
		cyc(4);
		chk("fault", 32'h0, fault_flag_oe);
		thermal_hot <= 1'b0;
		prot_supply_ok_b <= 1'b1;
		bus(1'b1, 8'h00, 32'h63);
		stp();
		undervoltage_lockout_a <= 1'b1;
		cyc(4);
		chk("bridge", 32'h0, bridge_en);
		chk("home", 32'h1, home_position_flag_oe);
		undervoltage_lockout_a <= 1'b0;
		cyc(6);
		chk("bridge", 32'h1, bridge_en);
		$display("supply test done");
	endtask
	task automatic t_standby();
		bus(1'b1, 8'h00, 32'h71);
		cyc(4);
		chk("home", 32'h0, home_position_flag_oe);
		chk("bridge", 32'h0, bridge_en);
		bus(1'b1, 8'h00, 32'h01);
		cyc(4);
		chk("home", 32'h0, home_position_flag_oe);
		chk("bridge", 32'h0, bridge_en);
		thermal_hot <= 1'b1;
		cyc(3);
		chk("fault", 32'h1, fault_flag_oe);
		thermal_hot <= 1'b0;
		chop();
		chop();
		chk("fault", 32'h0, fault_flag_oe);
		oc_switch <= 8'h02;
		cyc(170);
		oc_switch <= 8'h00;
		chk("fault", 32'h0, fault_flag_oe);
		bus(1'b1, 8'h00, 32'h63);
		stp();
		cyc(30);
		bus(1'b0, 8'h04, 32'h0);
		chk("position", 32'h0, {26'h0, d[13:8]});
		$display("standby test done");
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		go = 1'b0;
		thermal_hot = 1'b0;
		oc_switch = 8'h00;
		chop_charge_start = 1'b0;
		prot_supply_ok_a = 1'b1;
		prot_supply_ok_b = 1'b1;
		undervoltage_lockout_a = 1'b0;
		undervoltage_lockout_b = 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_init();
		t_step();
		t_modes();
		t_enlow();
		t_therm();
		t_oc();
		t_supply();
		t_standby();
		end_of_test();
	end
	// the whole sequence needs a little over a thousand cycles
	initial begin
		repeat (30000) @(posedge hclk);
		n_mismatch++;
		end_of_test();
	end
endmodule
